// ===== logic/ccpa_pkg.sv
// constants, register map and encodings for the capture/compare and pulse accumulator block
package ccpa_pkg;

	// widths
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int CH_N   = 8;
	localparam int CNT_W  = 16;
	localparam int IDX_W  = 3;

	// register byte addresses
	localparam logic [5:0] MODE_SEL_ADDR  = 6'h00;
	localparam logic [5:0] EDGE_SEL_ADDR  = 6'h01;
	localparam logic [5:0] CC_FIRST_ADDR  = 6'h10;
	localparam logic [5:0] CC_LAST_ADDR   = 6'h1f;
	localparam logic [5:0] CTRL_ADDR      = 6'h20;
	localparam logic [5:0] FLAG_ADDR      = 6'h21;
	localparam logic [5:0] COUNT_HI_ADDR  = 6'h22;
	localparam logic [5:0] COUNT_LO_ADDR  = 6'h23;

	// control register fields
	localparam int ENABLE_BIT   = 6;
	localparam int MODE_BIT     = 5;
	localparam int EDGE_BIT     = 4;
	localparam int CLK_SEL_HI   = 3;
	localparam int CLK_SEL_LO   = 2;
	localparam int OVF_IRQ_BIT  = 1;
	localparam int EDGE_IRQ_BIT = 0;

	// flag register fields
	localparam int OVF_FLAG_BIT  = 1;
	localparam int EDGE_FLAG_BIT = 0;

	// reset values
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  MODE_SEL_RESET = 8'h00;
	localparam logic [7:0]  EDGE_SEL_RESET = 8'h00;
	localparam logic [7:0]  HOLD_RESET     = 8'h00;
	localparam logic [15:0] CC_RESET       = 16'h0000;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;

	// count values at which the divided accumulator clocks fire
	localparam logic [7:0]  DIV256_WRAP    = 8'hff;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

	// channels that exist in this build, one bit each
	localparam logic [7:0] CHANNELS_PRESENT = 8'hff;

	// accumulator pin channel
	localparam int ACC_CHANNEL = 7;

	// counter clock sources
	typedef enum logic [1:0] {
		CLK_PRESCALER    = 2'b00,
		CLK_ACC          = 2'b01,
		CLK_ACC_DIV256   = 2'b10,
		CLK_ACC_DIV65536 = 2'b11
	} clk_sel_e;

	// read data sources for the cycle after a read strobe
	typedef enum logic [1:0] {
		RD_ZERO    = 2'b00,
		RD_BYTE    = 2'b01,
		RD_CC_HIGH = 2'b10,
		RD_CC_LOW  = 2'b11
	} rd_src_e;

endpackage

// ===== logic/cc_store.sv
// storage for the eight channel capture/compare words, with registered read and compare match
`timescale 1ns/1ps
module cc_store (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// software write port
	input  wire logic        sw_we_in,
	input  wire logic [2:0]  sw_idx_in,
	input  wire logic [15:0] sw_data_in,
	// capture write port
	input  wire logic [7:0]  cap_we_in,
	input  wire logic [15:0] cap_value_in,
	// read port
	input  wire logic [2:0]  rd_idx_in,
	output logic      [15:0] rd_data_out,
	// compare
	input  wire logic [7:0]  compare_en_in,
	input  wire logic [15:0] counter_in,
	output logic      [7:0]  match_out
);

	logic [15:0] mem [ccpa_pkg::CH_N];

	// per channel: capture in capture mode, software write in compare mode
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < ccpa_pkg::CH_N; i++) begin
				mem[i] <= ccpa_pkg::CC_RESET;
			end
		end else begin
			for (int i = 0; i < ccpa_pkg::CH_N; i++) begin
				if (cap_we_in[i]) begin
					mem[i] <= cap_value_in;
				end else if (sw_we_in && sw_idx_in == 3'(i)) begin
					mem[i] <= sw_data_in;
				end
			end
		end
	end

	// registered read word
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= ccpa_pkg::CC_RESET;
		end else begin
			rd_data_out <= mem[rd_idx_in];
		end
	end

	// compare against the free-running counter
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			match_out <= 8'h00;
		end else begin
			for (int i = 0; i < ccpa_pkg::CH_N; i++) begin
				match_out[i] <= compare_en_in[i] && (counter_in == mem[i]);
			end
		end
	end

endmodule // cc_store

// ===== logic/capture_compare_pulse_accumulator.sv
// channel capture/compare registers and 16-bit pulse accumulator with counter clock select
// Behaviour
// - each channel register captures the counter on an edge while the main timer is enabled, or holds a compare value
// - software writes land only while the channel is in compare mode
// - reset clears every channel register to zero
// - absent channels ignore writes and read as zero
// - accumulator enable works whether or not the main timer is enabled
// - accumulator input is the channel 7 pin
// - mode bit picks event or gated counting; both bits act only when enabled
// - event mode counts falling edges for edge bit 0, rising for 1
// - gated mode gates divide-by-64 ticks by pin level, flags the trailing edge
// - no divide-by-64 tick while the main timer is disabled
// - clock select picks prescaler, accumulator clock, or it divided by 256 or 65536
// - disabled accumulator forces the prescaler clock onto the counter
// - a new clock select acts at once
// - overflow interrupt request follows flag and its enable
// - input edge interrupt request follows flag and its enable
// - control register reads and writes at any time
// - overflow flag sets when the count wraps from all ones to zero
// - the pin is synchronised to the bus clock before edge detection
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module capture_compare_pulse_accumulator (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// register port
	input  wire logic [5:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        write_in,
	input  wire logic        read_in,
	output logic      [7:0]  rdata_out,
	// timer core
	input  wire logic        timer_enable_bit_in,
	input  wire logic [15:0] counter_value_in,
	input  wire logic        prescaler_tick_in,
	input  wire logic        prescaler_div64_tick_in,
	output logic             counter_clock_tick_out,
	// channel pins
	input  wire logic [7:0]  channel_pin_in,
	// channel events
	output logic      [7:0]  compare_match_out,
	output logic      [7:0]  capture_event_out,
	// accumulator interrupt requests
	output logic             acc_overflow_irq_out,
	output logic             acc_input_irq_out
);

	// address is one of the channel register bytes
	function automatic logic is_cc_addr(input logic [5:0] a);
		return (a >= ccpa_pkg::CC_FIRST_ADDR) && (a <= ccpa_pkg::CC_LAST_ADDR);
	endfunction
	// channel index of a channel register byte
	function automatic logic [2:0] cc_index(input logic [5:0] a);
		return a[3:1];
	endfunction
	// selected edge: rising when sel is 1, falling when 0
	function automatic logic pick_edge(input logic sel, input logic rise, input logic fall);
		return sel ? rise : fall;
	endfunction

	// registers
	logic [7:0]        channel_mode_select, capture_edge_sel, pulse_acc_control, rd_byte;
	logic [7:0]        cc_write_hold, count_write_hold, count_read_hold, cc_read_hold;
	logic              acc_overflow_flag, acc_input_edge_flag;
	logic [15:0]       pulse_acc_count;
	ccpa_pkg::rd_src_e rd_src;

	// pin synchronisers and edge history
	logic [7:0] pin_meta, pin_sync, pin_prev, pin_rise, pin_fall;

	// decoded accesses
	logic        wr_cc, wr_cc_low, sw_we;
	logic [2:0]  wr_ch;
	logic [15:0] sw_data, cc_word;
	logic [7:0]  cap_we;

	// accumulator controls
	logic               acc_enable, acc_gated, acc_edge, gate_level, div64_tick;
	logic               accumulator_clock, acc_input_event, acc_wrap, count_write, flag_clear_ok;
	ccpa_pkg::clk_sel_e clk_sel;

	// two-stage synchroniser, then one more stage for edges
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
			pin_prev <= 8'h00;
		end else begin
			pin_meta <= channel_pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign pin_rise = pin_sync & ~pin_prev;
	assign pin_fall = ~pin_sync & pin_prev;

	// channel register write decode
	assign wr_cc     = write_in && is_cc_addr(addr_in);
	assign wr_cc_low = wr_cc && addr_in[0];
	assign wr_ch     = cc_index(addr_in);
	assign sw_we     = wr_cc_low && channel_mode_select[wr_ch] && ccpa_pkg::CHANNELS_PRESENT[wr_ch];
	assign sw_data   = {cc_write_hold, wdata_in};

	// capture strobes per channel
	always_comb begin
		for (int i = 0; i < ccpa_pkg::CH_N; i++) begin
			cap_we[i] = ccpa_pkg::CHANNELS_PRESENT[i] && !channel_mode_select[i] && timer_enable_bit_in
				&& pick_edge(capture_edge_sel[i], pin_rise[i], pin_fall[i]);
		end
	end

	cc_store cc_store_inst (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.sw_we_in      (sw_we),
		.sw_idx_in     (wr_ch),
		.sw_data_in    (sw_data),
		.cap_we_in     (cap_we),
		.cap_value_in  (counter_value_in),
		.rd_idx_in     (cc_index(addr_in)),
		.rd_data_out   (cc_word),
		.compare_en_in (channel_mode_select & ccpa_pkg::CHANNELS_PRESENT),
		.counter_in    (counter_value_in),
		.match_out     (compare_match_out)
	);

	// capture event pulses
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			capture_event_out <= 8'h00;
		end else begin
			capture_event_out <= cap_we;
		end
	end

	// high byte of a channel write waits here for the low byte
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cc_write_hold <= ccpa_pkg::HOLD_RESET;
		end else if (wr_cc && !addr_in[0]) begin
			cc_write_hold <= wdata_in;
		end
	end

	// mode and edge select registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			channel_mode_select <= ccpa_pkg::MODE_SEL_RESET;
			capture_edge_sel    <= ccpa_pkg::EDGE_SEL_RESET;
		end else if (write_in) begin
			if (addr_in == ccpa_pkg::MODE_SEL_ADDR) begin
				channel_mode_select <= wdata_in & ccpa_pkg::CHANNELS_PRESENT;
			end else if (addr_in == ccpa_pkg::EDGE_SEL_ADDR) begin
				capture_edge_sel <= wdata_in & ccpa_pkg::CHANNELS_PRESENT;
			end
		end
	end

	// accumulator control register, writable at any time
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_acc_control <= ccpa_pkg::CTRL_RESET;
		end else if (write_in && addr_in == ccpa_pkg::CTRL_ADDR) begin
			pulse_acc_control <= wdata_in;
		end
	end

	assign acc_enable = pulse_acc_control[ccpa_pkg::ENABLE_BIT];
	assign acc_gated  = pulse_acc_control[ccpa_pkg::MODE_BIT];
	assign acc_edge   = pulse_acc_control[ccpa_pkg::EDGE_BIT];
	assign clk_sel    = ccpa_pkg::clk_sel_e'(pulse_acc_control[ccpa_pkg::CLK_SEL_HI:ccpa_pkg::CLK_SEL_LO]);

	// accumulator path, all from the synchronised channel 7 pin
	assign gate_level = acc_edge ? !pin_sync[ccpa_pkg::ACC_CHANNEL] : pin_sync[ccpa_pkg::ACC_CHANNEL];
	assign div64_tick = prescaler_div64_tick_in && timer_enable_bit_in;

	always_comb begin
		accumulator_clock = 1'b0;
		if (acc_enable) begin
			if (acc_gated) begin
				accumulator_clock = div64_tick && gate_level;
			end else begin
				accumulator_clock = acc_input_event;
			end
		end
	end

	// event mode flags the counted edge; gated mode flags the trailing edge of the gate
	assign acc_input_event = acc_enable && pick_edge(acc_edge, pin_rise[ccpa_pkg::ACC_CHANNEL],
		pin_fall[ccpa_pkg::ACC_CHANNEL]);

	assign acc_wrap    = accumulator_clock && (pulse_acc_count == ccpa_pkg::COUNT_ALL_ONES);
	assign count_write = write_in && addr_in == ccpa_pkg::COUNT_LO_ADDR;

	// accumulator count; software low-byte write loads the whole word
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_acc_count <= ccpa_pkg::COUNT_RESET;
		end else if (count_write) begin
			pulse_acc_count <= {count_write_hold, wdata_in};
		end else if (accumulator_clock) begin
			pulse_acc_count <= pulse_acc_count + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_write_hold <= ccpa_pkg::HOLD_RESET;
		end else if (write_in && addr_in == ccpa_pkg::COUNT_HI_ADDR) begin
			count_write_hold <= wdata_in;
		end
	end

	// flags: write one to clear while timer or accumulator is enabled; a new event wins
	assign flag_clear_ok = write_in && addr_in == ccpa_pkg::FLAG_ADDR && (timer_enable_bit_in || acc_enable);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_overflow_flag <= 1'b0;
		end else if (acc_wrap && !count_write) begin
			acc_overflow_flag <= 1'b1;
		end else if (flag_clear_ok && wdata_in[ccpa_pkg::OVF_FLAG_BIT]) begin
			acc_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_input_edge_flag <= 1'b0;
		end else if (acc_input_event) begin
			acc_input_edge_flag <= 1'b1;
		end else if (flag_clear_ok && wdata_in[ccpa_pkg::EDGE_FLAG_BIT]) begin
			acc_input_edge_flag <= 1'b0;
		end
	end

	// interrupt requests
	assign acc_overflow_irq_out = acc_overflow_flag && pulse_acc_control[ccpa_pkg::OVF_IRQ_BIT];
	assign acc_input_irq_out    = acc_input_edge_flag && pulse_acc_control[ccpa_pkg::EDGE_IRQ_BIT];

	// timer counter clock source, switched with no boundary wait
	always_comb begin
		counter_clock_tick_out = prescaler_tick_in;
		if (acc_enable) begin
			case (clk_sel)
				ccpa_pkg::CLK_PRESCALER: begin
					counter_clock_tick_out = prescaler_tick_in;
				end
				ccpa_pkg::CLK_ACC: begin
					counter_clock_tick_out = accumulator_clock;
				end
				ccpa_pkg::CLK_ACC_DIV256: begin
					counter_clock_tick_out = accumulator_clock && (pulse_acc_count[7:0] == ccpa_pkg::DIV256_WRAP);
				end
				ccpa_pkg::CLK_ACC_DIV65536: begin
					counter_clock_tick_out = acc_wrap;
				end
			endcase
		end
	end

	// read: source chosen at the strobe, data presented the next cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_src  <= ccpa_pkg::RD_ZERO;
			rd_byte <= 8'h00;
		end else begin
			rd_src  <= ccpa_pkg::RD_ZERO;
			rd_byte <= 8'h00;
			if (read_in) begin
				if (is_cc_addr(addr_in) && ccpa_pkg::CHANNELS_PRESENT[cc_index(addr_in)]) begin
					rd_src <= addr_in[0] ? ccpa_pkg::RD_CC_LOW : ccpa_pkg::RD_CC_HIGH;
				end else if (addr_in == ccpa_pkg::MODE_SEL_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= channel_mode_select;
				end else if (addr_in == ccpa_pkg::EDGE_SEL_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= capture_edge_sel;
				end else if (addr_in == ccpa_pkg::CTRL_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= pulse_acc_control;
				end else if (addr_in == ccpa_pkg::FLAG_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= {6'h00, acc_overflow_flag, acc_input_edge_flag};
				end else if (addr_in == ccpa_pkg::COUNT_HI_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= pulse_acc_count[15:8];
				end else if (addr_in == ccpa_pkg::COUNT_LO_ADDR) begin
					rd_src  <= ccpa_pkg::RD_BYTE;
					rd_byte <= count_read_hold;
				end
			end
		end
	end

	// high-byte reads freeze the matching low byte for the following low read
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_read_hold <= ccpa_pkg::HOLD_RESET;
		end else if (read_in && addr_in == ccpa_pkg::COUNT_HI_ADDR) begin
			count_read_hold <= pulse_acc_count[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cc_read_hold <= ccpa_pkg::HOLD_RESET;
		end else if (rd_src == ccpa_pkg::RD_CC_HIGH) begin
			cc_read_hold <= cc_word[7:0];
		end
	end

	// read data mux over registered sources
	always_comb begin
		case (rd_src)
			ccpa_pkg::RD_BYTE: begin
				rdata_out = rd_byte;
			end
			ccpa_pkg::RD_CC_HIGH: begin
				rdata_out = cc_word[15:8];
			end
			ccpa_pkg::RD_CC_LOW: begin
				rdata_out = cc_read_hold;
			end
			default: begin
				rdata_out = 8'h00;
			end
		endcase
	end

endmodule // capture_compare_pulse_accumulator

// ===== test/ccpa_checker_sva.sv
// port assertions for the capture/compare and pulse accumulator block
`timescale 1ns/1ps
module ccpa_checker (
	// clock and reset
	input wire logic       clk_in,
	input wire logic       rst_in,
	// register port
	input wire logic [5:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       write_in,
	input wire logic       read_in,
	input wire logic [7:0] rdata_out,
	// timer core and pin
	input wire logic       timer_enable_bit_in,
	input wire logic       prescaler_tick_in,
	input wire logic       counter_clock_tick_out,
	input wire logic [7:0] channel_pin_in,
	// interrupt requests
	input wire logic       acc_overflow_irq_out,
	input wire logic       acc_input_irq_out
);
	logic [7:0] ctrl;

	// copy of the control register seen from the bus
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			ctrl <= 8'h00;
		else if (write_in && addr_in == ccpa_pkg::CTRL_ADDR)
			ctrl <= wdata_in;
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence pin_quiet;
		$stable(channel_pin_in[7])[*4];
	endsequence
	sequence timer_off;
		(!timer_enable_bit_in)[*3];
	endsequence

	a_disabled_prescaler: assert property (!ctrl[6] |-> counter_clock_tick_out == prescaler_tick_in)
		else $error("counter tick not from prescaler while accumulator off");
	a_prescaler_select: assert property (ctrl[6] && ctrl[3:2] == 2'b00 |-> counter_clock_tick_out == prescaler_tick_in)
		else $error("select 00 does not pass prescaler tick");
	a_quiet_pin_tick: assert property ((pin_quiet ##0 (ctrl[6] && !ctrl[5] && ctrl[3:2] != 2'b00)) |-> !counter_clock_tick_out)
		else $error("accumulator clock tick without pin edge");
	a_gated_timer_off: assert property ((timer_off ##0 (ctrl[6] && ctrl[5] && ctrl[3:2] == 2'b01)) |-> !counter_clock_tick_out)
		else $error("gated tick while timer disabled");
	a_ovf_irq_gate: assert property (!ctrl[1] |-> !acc_overflow_irq_out)
		else $error("overflow request while its enable is low");
	a_edge_irq_gate: assert property (!ctrl[0] |-> !acc_input_irq_out)
		else $error("edge request while its enable is low");
	a_ctrl_readback: assert property (read_in && addr_in == ccpa_pkg::CTRL_ADDR |=> rdata_out[6:0] == $past(ctrl[6:0]))
		else $error("control read data differs from last write");
	a_read_idle_zero: assert property (!read_in |=> rdata_out == 8'h00)
		else $error("read data not zero outside read answer");
endmodule // ccpa_checker

bind capture_compare_pulse_accumulator ccpa_checker ccpa_checker_inst (.clk_in, .rst_in, .addr_in, .wdata_in,
	.write_in, .read_in, .rdata_out, .timer_enable_bit_in, .prescaler_tick_in, .counter_clock_tick_out,
	.channel_pin_in, .acc_overflow_irq_out, .acc_input_irq_out);

// ===== test/test_capture_compare_pulse_accumulator.sv
// self-checking bench for the capture/compare and pulse accumulator block
`timescale 1ns/1ps
module test_capture_compare_pulse_accumulator;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [5:0]  addr_in = 6'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        write_in = 1'b0;
	logic        read_in = 1'b0;
	logic [7:0]  rdata_out;
	logic        timer_enable_bit_in = 1'b0;
	logic [15:0] counter_value_in = 16'h0000;
	logic        prescaler_tick_in = 1'b0;
	logic        prescaler_div64_tick_in = 1'b0;
	logic        counter_clock_tick_out;
	logic [7:0]  channel_pin_in = 8'h00;
	logic [7:0]  compare_match_out;
	logic [7:0]  capture_event_out;
	logic        acc_overflow_irq_out;
	logic        acc_input_irq_out;
	logic [7:0]  exp_q[$];
	logic        rd_seen = 1'b0;
	logic [7:0]  seed = 8'h2d;
	logic [15:0] cc[8];
	logic [7:0]  exp_m;
	logic [15:0] pre[4] = '{16'h0000, 16'h0000, 16'h00fe, 16'hfffe};
	int          nt[4] = '{3, 2, 1, 1};
	int          fail_count = 0;
	int          cmp_count = 0;
	int          tick_count = 0;
	int          cap_count = 0;

	always #50 clk_in = ~clk_in;

	capture_compare_pulse_accumulator capture_compare_pulse_accumulator_inst (.clk_in, .rst_in, .addr_in,
		.wdata_in, .write_in, .read_in, .rdata_out, .timer_enable_bit_in, .counter_value_in, .prescaler_tick_in,
		.prescaler_div64_tick_in, .counter_clock_tick_out, .channel_pin_in, .compare_match_out,
		.capture_event_out, .acc_overflow_irq_out, .acc_input_irq_out);

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		write_in <= w;
		read_in <= r;
		addr_in <= a;
		wdata_in <= d;
	endtask

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 6'h00, 8'h00);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic wr16(input logic [5:0] a, input logic [15:0] d);
		bus(1'b1, 1'b0, a, d[15:8]);
		bus(1'b1, 1'b0, a + 6'h01, d[7:0]);
	endtask

	task automatic rd16(input logic [5:0] a, input logic [15:0] exp);
		rd(a, exp[15:8]);
		rd(a + 6'h01, exp[7:0]);
	endtask

	task automatic pulse7(input logic lvl);
		channel_pin_in[7] <= lvl;
		idle(5);
	endtask

	task automatic ticks(input logic p, input int n);
		repeat (n) begin
			@(posedge clk_in);
			prescaler_tick_in <= p;
			prescaler_div64_tick_in <= ~p;
			@(posedge clk_in);
			prescaler_tick_in <= 1'b0;
			prescaler_div64_tick_in <= 1'b0;
		end
	endtask

	task automatic irq_chk(input logic [7:0] c, input logic ovf, input logic edg);
		bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, c);
		idle(1);
		@(negedge clk_in);
		chk_data(16'(acc_overflow_irq_out), 16'(ovf));
		chk_data(16'(acc_input_irq_out), 16'(edg));
	endtask

	// read answers and tick events
	always @(posedge clk_in) rd_seen <= read_in;
	always @(negedge clk_in) begin
		if (counter_clock_tick_out === 1'b1)
			tick_count++;
		if (capture_event_out[3] === 1'b1)
			cap_count++;
		if (rd_seen === 1'b1)
			chk_data(16'(rdata_out), 16'(exp_q.pop_front()));
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(ccpa_pkg::CTRL_ADDR, 8'h00);
		for (int i = 0; i < 8; i++)
			rd16(6'h10 + 6'(2 * i), 16'h0000);
		rd(6'h05, 8'h00);
		rd(6'h30, 8'h00);
		wr16(6'h14, 16'h5a5a);
		rd16(6'h14, 16'h0000);
		$display("reset values done");
		bus(1'b1, 1'b0, ccpa_pkg::MODE_SEL_ADDR, 8'hff);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			cc[i][15:8] = seed;
			seed = lfsr(seed);
			cc[i][7:0] = seed;
			wr16(6'h10 + 6'(2 * i), cc[i]);
		end
		for (int i = 0; i < 8; i++)
			rd16(6'h10 + 6'(2 * i), cc[i]);
		for (int j = 0; j < 8; j++)
			exp_m[j] = (cc[j] == cc[5]);
		counter_value_in <= cc[5];
		idle(3);
		@(negedge clk_in);
		chk_data(16'(compare_match_out), 16'(exp_m));
		$display("compare registers done");
		bus(1'b1, 1'b0, ccpa_pkg::MODE_SEL_ADDR, 8'hf7);
		bus(1'b1, 1'b0, ccpa_pkg::EDGE_SEL_ADDR, 8'h08);
		timer_enable_bit_in <= 1'b1;
		counter_value_in <= 16'h4321;
		cap_count = 0;
		channel_pin_in[3] <= 1'b1;
		idle(6);
		wr16(6'h16, 16'h1111);
		rd16(6'h16, 16'h4321);
		idle(2);
		chk_data(16'(cap_count), 16'h0001);
		$display("capture done");
		timer_enable_bit_in <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, 8'h00);
			pulse7(~e[0]);
			wr16(ccpa_pkg::COUNT_HI_ADDR, 16'h0000);
			pulse7(e[0]);
			pulse7(~e[0]);
			bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, {3'b010, e[0], 4'h0});
			bus(1'b1, 1'b0, ccpa_pkg::FLAG_ADDR, 8'h03);
			pulse7(e[0]);
			pulse7(~e[0]);
			rd16(ccpa_pkg::COUNT_HI_ADDR, 16'h0001);
			rd(ccpa_pkg::FLAG_ADDR, 8'h01);
		end
		irq_chk(8'h50, 1'b0, 1'b0);
		irq_chk(8'h51, 1'b0, 1'b1);
		wr16(ccpa_pkg::COUNT_HI_ADDR, 16'hffff);
		pulse7(1'b1);
		rd16(ccpa_pkg::COUNT_HI_ADDR, 16'h0000);
		rd(ccpa_pkg::FLAG_ADDR, 8'h03);
		irq_chk(8'h52, 1'b1, 1'b0);
		irq_chk(8'h50, 1'b0, 1'b0);
		bus(1'b1, 1'b0, ccpa_pkg::FLAG_ADDR, 8'h03);
		$display("event counting done");
		timer_enable_bit_in <= 1'b1;
		for (int e = 0; e < 2; e++) begin
			pulse7(e[0]);
			bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, {3'b011, e[0], 4'h4});
			bus(1'b1, 1'b0, ccpa_pkg::FLAG_ADDR, 8'h03);
			wr16(ccpa_pkg::COUNT_HI_ADDR, 16'h0000);
			tick_count = 0;
			pulse7(~e[0]);
			ticks(1'b0, 5);
			pulse7(e[0]);
			ticks(1'b0, 3);
			rd16(ccpa_pkg::COUNT_HI_ADDR, 16'h0005);
			rd(ccpa_pkg::FLAG_ADDR, 8'h01);
			idle(2);
			chk_data(16'(tick_count), 16'h0005);
		end
		timer_enable_bit_in <= 1'b0;
		pulse7(1'b0);
		tick_count = 0;
		ticks(1'b0, 4);
		rd16(ccpa_pkg::COUNT_HI_ADDR, 16'h0005);
		idle(2);
		chk_data(16'(tick_count), 16'h0000);
		$display("gated accumulation done");
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, 8'(s << 2));
			tick_count = 0;
			ticks(1'b1, 3);
			idle(2);
			chk_data(16'(tick_count), 16'h0003);
		end
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 1'b0, ccpa_pkg::CTRL_ADDR, 8'h50 | 8'(s << 2));
			wr16(ccpa_pkg::COUNT_HI_ADDR, pre[s]);
			tick_count = 0;
			ticks(1'b1, (s == 0) ? 3 : 2);
			repeat ((s == 0) ? 0 : 2) begin
				pulse7(1'b1);
				pulse7(1'b0);
			end
			idle(2);
			chk_data(16'(tick_count), 16'(nt[s]));
		end
		$display("clock select done");
		complete_run();
	end
endmodule // test_capture_compare_pulse_accumulator
